// ### core/sysctl_params.svh
`ifndef SYSCTL_PARAMS_SVH
`define SYSCTL_PARAMS_SVH

// register offsets (byte addresses, one aligned word each)
`define SC_OFF_PBOR       8'h00
`define SC_OFF_CAUSE      8'h04
`define SC_OFF_SOFT0      8'h08
`define SC_OFF_SOFT1      8'h0c
`define SC_OFF_SOFT2      8'h10
`define SC_OFF_MAIN_OSC   8'h14
`define SC_OFF_REGUL      8'h18
`define SC_OFF_RUN_CFG    8'h1c
`define SC_OFF_WDLOAD     8'h20
`define SC_OFF_WDCTL      8'h24

// por_brownout_control fields
`define SC_BOR_EN_BIT     1

// reset_cause_record fields
`define SC_CAUSE_EXT      0
`define SC_CAUSE_POR      1
`define SC_CAUSE_BOR      2
`define SC_CAUSE_WDT      3
`define SC_CAUSE_SW       4
`define SC_CAUSE_OSC_FAIL 16
`define SC_CAUSE_W        17

// main_osc_control fields
`define SC_CHECK_EN_BIT   0

// run_clock_config fields and reset value
`define SC_RUN_CFG_SKIP_BIT 11
`define SC_RUN_CFG_SRC_LSB  4
`define SC_RUN_CFG_SRC_MSB  5
`define SC_RUN_CFG_EXT_LSB  28
`define SC_RUN_CFG_EXT_MSB  30
`define SC_RUN_CFG_USE_EXT  31
`define SC_RUN_CFG_RESET    32'h0000_0810

// clock source codes
`define SC_SRC_MAIN       2'h0
`define SC_SRC_INT        2'h1
`define SC_SRC_INT_DIV4   2'h2
`define SC_SRC_LF30K      2'h3
`define SC_SRC_EXT_RTC    3'h7

// watchdog control fields
`define SC_WD_RUN_BIT     0
`define SC_WD_RSTEN_BIT   1
`define SC_WD_INT_BIT     2

// timing
`define SC_CLK_MHZ        100
`define SC_RST_HOLD_NS    200
`define SC_RST_HOLD_CYC   ((`SC_RST_HOLD_NS * `SC_CLK_MHZ + 999) / 1000)
`define SC_DIV4_LAST      2'h3

// bus answers
`define SC_RESP_OKAY      2'h0
`define SC_RESP_SLVERR    2'h2

`endif

// ### core/sysctl_pkg.sv
package sysctl_pkg;
  typedef enum logic [2:0] {
    SRC_MAIN,
    SRC_INT,
    SRC_INT_DIV4,
    SRC_LF30K,
    SRC_RTC,
    SRC_PLL
  } clk_src_t;

  typedef enum logic [1:0] {
    SW_RUN,
    SW_DRAIN,
    SW_WAIT
  } clk_sw_state_t;
endpackage

// ### core/sysctl_reset_clock.sv
`include "sysctl_params.svh"
module sysctl_reset_clock #(
  parameter int SOFT_REGS = 3,
  parameter int TRIM_W    = 8
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic [7:0]              awaddr,
  input  wire logic                    awvalid,
  output logic                         awready,
  input  wire logic [31:0]             wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  input  wire logic [7:0]              araddr,
  input  wire logic                    arvalid,
  output logic                         arready,
  output logic [31:0]                  rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  input  wire logic                    ext_reset_n,
  input  wire logic                    brownout_detect,
  input  wire logic                    core_system_reset_request,
  input  wire logic                    osc_fail_detect,
  input  wire logic                    nmi_pin,
  input  wire logic                    nmi_pin_enable,
  input  wire logic                    main_osc_tick,
  input  wire logic                    internal_osc_tick,
  input  wire logic                    lf30k_osc_tick,
  input  wire logic                    rtc_osc_tick,
  input  wire logic                    pll_tick,
  output logic                         core_reset_n,
  output logic [32*SOFT_REGS-1:0]      periph_reset_n,
  output logic                         nmi_out,
  output logic                         brownout_irq,
  output logic                         watchdog_irq,
  output logic [TRIM_W-1:0]            regulator_voltage_trim,
  output logic                         osc_check_enable,
  output logic                         pll_enable,
  output logic                         system_clock_en,
  output logic [2:0]                   clock_source_active
);

  // ---------------- register state ----------------
  logic                      bor_en_reg, bor_en_next;
  logic [`SC_CAUSE_W-1:0]    cause_reg, cause_next;
  logic [31:0]               soft_reg [SOFT_REGS], soft_next [SOFT_REGS];
  logic                      check_en_reg, check_en_next;
  logic [TRIM_W-1:0]         trim_reg, trim_next;
  logic [31:0]               run_cfg_reg, run_cfg_next;
  logic [31:0]               wd_load_reg, wd_load_next;
  logic                      wd_run_reg, wd_run_next;
  logic                      wd_rsten_reg, wd_rsten_next;
  logic                      wd_int_reg, wd_int_next;
  logic [31:0]               wd_cnt_reg, wd_cnt_next;
  logic                      wd_rst_req_reg, wd_rst_req_next;
  logic                      osc_nmi_reg, osc_nmi_next;
  logic                      bvalid_reg, bvalid_next;
  logic [1:0]                bresp_reg, bresp_next;
  logic                      rvalid_reg, rvalid_next;
  logic [1:0]                rresp_reg, rresp_next;
  logic [31:0]               rdata_reg, rdata_next;

  logic        wr_fire, rd_fire, sys_rst;
  logic [31:0] rd_word;
  logic        rd_hit;
  logic        bor_src, osc_src, req_any, wd_zero;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = d[8*i +: 8];
      end
    end
    return r;
  endfunction

  // write address and data are taken together, only with no answer pending
  assign awready = awvalid & wvalid & ~bvalid_reg;
  assign wready  = awready;
  assign arready = ~rvalid_reg;
  assign wr_fire = awready;
  assign rd_fire = arvalid & arready;
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign rvalid  = rvalid_reg;
  assign rresp   = rresp_reg;
  assign rdata   = rdata_reg;

  assign bor_src = brownout_detect & bor_en_reg;
  assign osc_src = osc_fail_detect & check_en_reg;
  assign wd_zero = wd_run_reg & (wd_cnt_reg == 32'h0);

  always_comb begin
    rd_hit  = 1'b1;
    rd_word = 32'h0;
    case (araddr)
      `SC_OFF_PBOR:   rd_word[`SC_BOR_EN_BIT] = bor_en_reg;
      `SC_OFF_CAUSE:  rd_word[`SC_CAUSE_W-1:0] = cause_reg;
      `SC_OFF_SOFT0:  rd_word = soft_reg[0];
      `SC_OFF_SOFT1:  rd_word = soft_reg[1];
      `SC_OFF_SOFT2:  rd_word = soft_reg[2];
      `SC_OFF_MAIN_OSC: rd_word[`SC_CHECK_EN_BIT] = check_en_reg;
      `SC_OFF_REGUL:  rd_word[TRIM_W-1:0] = trim_reg;
      `SC_OFF_RUN_CFG: rd_word = run_cfg_reg;
      `SC_OFF_WDLOAD: rd_word = wd_load_reg;
      `SC_OFF_WDCTL: begin
        rd_word[`SC_WD_RUN_BIT]   = wd_run_reg;
        rd_word[`SC_WD_RSTEN_BIT] = wd_rsten_reg;
        rd_word[`SC_WD_INT_BIT]   = wd_int_reg;
      end
      default:        rd_hit = 1'b0;
    endcase
  end

  // ---------------- registers, watchdog, cause record ----------------
  always_comb begin
    logic [31:0] wv;
    logic        hit;
    logic [31:0] cw;
    wv            = 32'h0;
    hit           = 1'b0;
    cw            = 32'h0;
    bor_en_next   = bor_en_reg;
    cause_next    = cause_reg;
    soft_next     = soft_reg;
    check_en_next = check_en_reg;
    trim_next     = trim_reg;
    run_cfg_next  = run_cfg_reg;
    wd_load_next  = wd_load_reg;
    wd_run_next   = wd_run_reg;
    wd_rsten_next = wd_rsten_reg;
    wd_int_next   = wd_int_reg;
    wd_cnt_next   = wd_cnt_reg;
    wd_rst_req_next = 1'b0;
    osc_nmi_next  = osc_nmi_reg;
    bvalid_next   = bvalid_reg & ~bready;
    bresp_next    = bresp_reg;
    rvalid_next   = rvalid_reg & ~rready;
    rresp_next    = rresp_reg;
    rdata_next    = rdata_reg;

    if (wr_fire) begin
      hit = 1'b1;
      case (awaddr)
        `SC_OFF_PBOR: begin
          wv = merge({31'h0, bor_en_reg} << `SC_BOR_EN_BIT, wdata, wstrb);
          bor_en_next = wv[`SC_BOR_EN_BIT];
        end
        // write one to clear a cause bit
        `SC_OFF_CAUSE:  cw = merge(32'h0, wdata, wstrb);
        `SC_OFF_SOFT0:  soft_next[0] = merge(soft_reg[0], wdata, wstrb);
        `SC_OFF_SOFT1:  soft_next[1] = merge(soft_reg[1], wdata, wstrb);
        `SC_OFF_SOFT2:  soft_next[2] = merge(soft_reg[2], wdata, wstrb);
        `SC_OFF_MAIN_OSC: begin
          wv = merge({31'h0, check_en_reg}, wdata, wstrb);
          check_en_next = wv[`SC_CHECK_EN_BIT];
        end
        `SC_OFF_REGUL: begin
          wv = merge(32'(trim_reg), wdata, wstrb);
          trim_next = wv[TRIM_W-1:0];
        end
        `SC_OFF_RUN_CFG: run_cfg_next = merge(run_cfg_reg, wdata, wstrb);
        `SC_OFF_WDLOAD: begin
          wd_load_next = merge(wd_load_reg, wdata, wstrb);
          wd_cnt_next  = wd_load_next;
        end
        `SC_OFF_WDCTL: begin
          wv = merge(32'h0, wdata, wstrb);
          wd_run_next   = wv[`SC_WD_RUN_BIT];
          wd_rsten_next = wv[`SC_WD_RSTEN_BIT];
          if (wv[`SC_WD_INT_BIT]) begin
            wd_int_next = 1'b0;
          end
        end
        default: hit = 1'b0;
      endcase
      bvalid_next = 1'b1;
      bresp_next  = hit ? `SC_RESP_OKAY : `SC_RESP_SLVERR;
    end

    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = rd_hit ? `SC_RESP_OKAY : `SC_RESP_SLVERR;
      rdata_next  = rd_word;
    end

    // watchdog: decrement, first zero raises flag, second zero resets
    if (wd_run_reg) begin
      if (wd_zero) begin
        wd_cnt_next = wd_load_reg;
        // timeout beats a software clear in the same cycle
        wd_int_next = 1'b1;
        if (wd_int_reg && wd_rsten_reg) begin
          wd_rst_req_next = 1'b1;
        end
      end else if (!(wr_fire && awaddr == `SC_OFF_WDLOAD)) begin
        wd_cnt_next = wd_cnt_reg - 32'h1;
      end
    end

    // cause record: software clear first, hardware set wins
    cause_next = cause_reg & ~cw[`SC_CAUSE_W-1:0];
    if (cw[`SC_CAUSE_OSC_FAIL]) begin
      osc_nmi_next = 1'b0;
    end
    if (!ext_reset_n) begin
      cause_next = '0;
      cause_next[`SC_CAUSE_EXT] = 1'b1;
    end else if (osc_src) begin
      // power-on class: other causes are dropped
      cause_next = '0;
      cause_next[`SC_CAUSE_OSC_FAIL] = 1'b1;
      osc_nmi_next = 1'b1;
    end else begin
      if (bor_src) begin
        cause_next[`SC_CAUSE_BOR] = 1'b1;
      end
      if (core_system_reset_request) begin
        cause_next[`SC_CAUSE_SW] = 1'b1;
      end
      if (wd_rst_req_reg) begin
        cause_next[`SC_CAUSE_WDT] = 1'b1;
      end
    end

    // system reset stops the watchdog, clears its flag and enables, reloads its counter from the load value, and clears the soft resets
    if (sys_rst) begin
      wd_run_next   = 1'b0;
      wd_rsten_next = 1'b0;
      wd_int_next   = 1'b0;
      wd_cnt_next   = wd_load_reg;
      for (int i = 0; i < SOFT_REGS; i++) begin
        soft_next[i] = 32'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bor_en_reg     <= 1'b0;
      cause_reg      <= `SC_CAUSE_W'(1) << `SC_CAUSE_POR;
      for (int i = 0; i < SOFT_REGS; i++) begin
        soft_reg[i]  <= 32'h0;
      end
      check_en_reg   <= 1'b0;
      trim_reg       <= '0;
      run_cfg_reg    <= `SC_RUN_CFG_RESET;
      wd_load_reg    <= 32'h0;
      wd_run_reg     <= 1'b0;
      wd_rsten_reg   <= 1'b0;
      wd_int_reg     <= 1'b0;
      wd_cnt_reg     <= 32'h0;
      wd_rst_req_reg <= 1'b0;
      osc_nmi_reg    <= 1'b0;
      bvalid_reg     <= 1'b0;
      bresp_reg      <= `SC_RESP_OKAY;
      rvalid_reg     <= 1'b0;
      rresp_reg      <= `SC_RESP_OKAY;
      rdata_reg      <= 32'h0;
    end else begin
      bor_en_reg     <= bor_en_next;
      cause_reg      <= cause_next;
      soft_reg       <= soft_next;
      check_en_reg   <= check_en_next;
      trim_reg       <= trim_next;
      run_cfg_reg    <= run_cfg_next;
      wd_load_reg    <= wd_load_next;
      wd_run_reg     <= wd_run_next;
      wd_rsten_reg   <= wd_rsten_next;
      wd_int_reg     <= wd_int_next;
      wd_cnt_reg     <= wd_cnt_next;
      wd_rst_req_reg <= wd_rst_req_next;
      osc_nmi_reg    <= osc_nmi_next;
      bvalid_reg     <= bvalid_next;
      bresp_reg      <= bresp_next;
      rvalid_reg     <= rvalid_next;
      rresp_reg      <= rresp_next;
      rdata_reg      <= rdata_next;
    end
  end

  // ---------------- reset sequencing ----------------
  logic        core_rst_n_reg, core_rst_n_next;
  logic [7:0]  hold_reg, hold_next;
  logic [32*SOFT_REGS-1:0] prst_n_reg, prst_n_next;
  logic        nmi_reg, nmi_next;

  // brown-out, only while bor_en_reg is set, behaves like the pin and holds while it persists
  assign req_any = ~ext_reset_n | bor_src | core_system_reset_request
                 | wd_rst_req_reg | osc_src;
  assign sys_rst = ~core_rst_n_reg;

  always_comb begin
    hold_next       = hold_reg;
    core_rst_n_next = core_rst_n_reg;
    if (req_any) begin
      hold_next       = 8'(`SC_RST_HOLD_CYC);
      core_rst_n_next = 1'b0;
    end else if (hold_reg != 8'h0) begin
      hold_next = hold_reg - 8'h1;
    end else begin
      core_rst_n_next = 1'b1;
    end
    // one bit per unit drives every clock domain of that unit
    for (int i = 0; i < SOFT_REGS; i++) begin
      prst_n_next[32*i +: 32] = ~soft_reg[i] & {32{core_rst_n_reg}};
    end
    // pin only counts once routed as the alternate function
    nmi_next = (nmi_pin & nmi_pin_enable) | (osc_nmi_reg & core_rst_n_reg);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hold_reg       <= 8'(`SC_RST_HOLD_CYC);
      core_rst_n_reg <= 1'b0;
      prst_n_reg     <= '0;
      nmi_reg        <= 1'b0;
    end else begin
      hold_reg       <= hold_next;
      core_rst_n_reg <= core_rst_n_next;
      prst_n_reg     <= prst_n_next;
      nmi_reg        <= nmi_next;
    end
  end

  // ---------------- clock source selection ----------------
  sysctl_pkg::clk_src_t      want_src, cur_reg, cur_next;
  sysctl_pkg::clk_sw_state_t sw_reg, sw_next;
  logic [1:0] div4_reg, div4_next;
  logic [5:0] tick;
  logic       sclk_en_reg, sclk_en_next;

  always_comb begin
    div4_next = internal_osc_tick ? div4_reg + 2'h1 : div4_reg;
    tick = '0;
    tick[sysctl_pkg::SRC_MAIN]     = main_osc_tick;
    tick[sysctl_pkg::SRC_INT]      = internal_osc_tick;
    tick[sysctl_pkg::SRC_INT_DIV4] = internal_osc_tick & (div4_reg == `SC_DIV4_LAST);
    tick[sysctl_pkg::SRC_LF30K]    = lf30k_osc_tick;
    tick[sysctl_pkg::SRC_RTC]      = rtc_osc_tick;
    tick[sysctl_pkg::SRC_PLL]      = pll_tick;
    if (!run_cfg_reg[`SC_RUN_CFG_SKIP_BIT]) begin
      want_src = sysctl_pkg::SRC_PLL;
    end else if (run_cfg_reg[`SC_RUN_CFG_USE_EXT] &&
                 run_cfg_reg[`SC_RUN_CFG_EXT_MSB:`SC_RUN_CFG_EXT_LSB] == `SC_SRC_EXT_RTC) begin
      want_src = sysctl_pkg::SRC_RTC;
    end else begin
      case (run_cfg_reg[`SC_RUN_CFG_SRC_MSB:`SC_RUN_CFG_SRC_LSB])
        `SC_SRC_MAIN:     want_src = sysctl_pkg::SRC_MAIN;
        `SC_SRC_INT:      want_src = sysctl_pkg::SRC_INT;
        `SC_SRC_INT_DIV4: want_src = sysctl_pkg::SRC_INT_DIV4;
        `SC_SRC_LF30K:    want_src = sysctl_pkg::SRC_LF30K;
        default:          want_src = sysctl_pkg::SRC_INT;
      endcase
    end
    // drain the old period, then start on a whole period of the new one
    cur_next = cur_reg;
    sw_next  = sw_reg;
    case (sw_reg)
      sysctl_pkg::SW_RUN: begin
        if (want_src != cur_reg) begin
          sw_next = sysctl_pkg::SW_DRAIN;
        end
      end
      sysctl_pkg::SW_DRAIN: begin
        if (tick[cur_reg]) begin
          sw_next = sysctl_pkg::SW_WAIT;
        end
      end
      sysctl_pkg::SW_WAIT: begin
        if (tick[want_src]) begin
          cur_next = want_src;
          sw_next  = sysctl_pkg::SW_RUN;
        end
      end
      default: sw_next = sysctl_pkg::SW_RUN;
    endcase
    sclk_en_next = (sw_reg == sysctl_pkg::SW_RUN) && (want_src == cur_reg) && tick[cur_reg];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div4_reg    <= 2'h0;
      cur_reg     <= sysctl_pkg::SRC_INT;
      sw_reg      <= sysctl_pkg::SW_RUN;
      sclk_en_reg <= 1'b0;
    end else begin
      div4_reg    <= div4_next;
      cur_reg     <= cur_next;
      sw_reg      <= sw_next;
      sclk_en_reg <= sclk_en_next;
    end
  end

  assign core_reset_n           = core_rst_n_reg;
  assign periph_reset_n         = prst_n_reg;
  assign nmi_out                = nmi_reg;
  assign brownout_irq           = brownout_detect & ~bor_en_reg;
  assign watchdog_irq           = wd_int_reg;
  assign regulator_voltage_trim = trim_reg;
  assign osc_check_enable       = check_en_reg;
  assign pll_enable             = ~run_cfg_reg[`SC_RUN_CFG_SKIP_BIT];
  assign system_clock_en        = sclk_en_reg;
  assign clock_source_active    = cur_reg;

  // ---------------- assertions ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_wdt_second;
    wd_zero && wd_int_reg && wd_rsten_reg;
  endsequence
  sequence s_core_held;
    !core_reset_n [*2];
  endsequence

  a_bor_gated: assert property (bor_src |=> !core_reset_n)
    else $error("enabled brown-out did not reset");
  a_bor_held: assert property (bor_src [*3] |-> s_core_held)
    else $error("reset released during brown-out");
  a_bor_cause: assert property (bor_src && ext_reset_n && !osc_src |=>
    cause_reg[`SC_CAUSE_BOR])
    else $error("brown-out not recorded");
  a_soft_periph: assert property (soft_reg[0][0] |=> !periph_reset_n[0])
    else $error("soft reset bit did not reset unit");
  a_sysreq_reset: assert property (core_system_reset_request |=> s_core_held)
    else $error("core request did not reset");
  a_wdt_first: assert property (wd_zero && !wd_int_reg && !sys_rst && !wr_fire |=>
    wd_int_reg && wd_cnt_reg == $past(wd_load_reg))
    else $error("watchdog first timeout wrong");
  a_wdt_second: assert property (s_wdt_second |=> wd_rst_req_reg ##1 !core_reset_n)
    else $error("watchdog second timeout no reset");
  a_osc_fail: assert property (osc_src && ext_reset_n |=>
    !core_reset_n && cause_reg[`SC_CAUSE_OSC_FAIL])
    else $error("osc failure not handled");
  a_nmi_gate: assert property (nmi_pin && !nmi_pin_enable && !osc_nmi_reg |=> !nmi_out)
    else $error("disabled nmi pin passed");
  a_release_sync: assert property ($rose(core_reset_n) |-> !$past(req_any) &&
    $past(hold_reg) == 8'h0)
    else $error("reset released early");
  a_clk_clean: assert property (system_clock_en |-> $past(sw_reg) == sysctl_pkg::SW_RUN)
    else $error("clock pulse during switch");
  a_por_source: assert property ($rose(aresetn) |-> cur_reg == sysctl_pkg::SRC_INT)
    else $error("not on internal osc after reset");

endmodule

// ### verif/osc_ticks_model.sv
module osc_ticks_model (
  input  wire logic aclk,
  output logic      main_t,
  output logic      int_t,
  output logic      lf_t,
  output logic      rtc_t,
  output logic      pll_t
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt = 8'h00;
  // unequal periods so a switch must really wait on both sources
  always_ff @(posedge aclk) begin
    cnt    <= cnt + 8'h01;
    main_t <= (cnt % 2) == 0;
    int_t  <= (cnt % 3) == 0;
    lf_t   <= (cnt % 5) == 0;
    rtc_t  <= (cnt % 7) == 0;
    pll_t  <= 1'b1;
  end
endmodule

// ### verif/test_system_reset_nmi_clock_source_ctrl.sv
`include "sysctl_params.svh"
module test_system_reset_nmi_clock_source_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, arvalid = 0, bready = 1, rready = 1;
  logic ext_n = 1, bod = 0, creq = 0, ofail = 0, nmi_p = 0, nmi_en = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, trim;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [3:0] wstrb = 4'hf;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, core_n, nmi_o, bo_irq, wd_irq;
  logic mt, it, lt, rt, pt, cken, pllen, sclk_en;
  logic [95:0] prst_n;
  logic [2:0] src_act;
  int err_total = 0, cmp_count = 0, cyc = 0;
  logic [31:0] cfg [6] = '{32'h800, 32'h820, 32'h830, 32'hf000_0810, 32'h010, 32'h810};
  logic [2:0] exp_src [6] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h5, 3'h1};
  osc_ticks_model ticks_u (.aclk(aclk), .main_t(mt), .int_t(it), .lf_t(lt), .rtc_t(rt),
    .pll_t(pt));
  sysctl_reset_clock dut_u (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .ext_reset_n(ext_n), .brownout_detect(bod),
    .core_system_reset_request(creq), .osc_fail_detect(ofail), .nmi_pin(nmi_p),
    .nmi_pin_enable(nmi_en), .main_osc_tick(mt), .internal_osc_tick(it),
    .lf30k_osc_tick(lt), .rtc_osc_tick(rt), .pll_tick(pt), .core_reset_n(core_n),
    .periph_reset_n(prst_n), .nmi_out(nmi_o), .brownout_irq(bo_irq), .watchdog_irq(wd_irq),
    .regulator_voltage_trim(trim), .osc_check_enable(cken), .pll_enable(pllen),
    .system_clock_en(sclk_en), .clock_source_active(src_act));
  initial forever #5 aclk = ~aclk;
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      results();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1;
    do @(posedge aclk); while (!(awready && wready));
    awvalid <= 0; wvalid <= 0;
    do @(posedge aclk); while (!bvalid);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a; arvalid <= 1;
    do @(posedge aclk); while (!arready);
    arvalid <= 0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic t_power_on();
    chk(src_act, 3'h1);
    rd(`SC_OFF_PBOR, rd_v);
    chk(rd_v, 32'h0);
    rd(`SC_OFF_CAUSE, rd_v);
    chk(rd_v, 32'h2);
    rd(8'hf0, rd_v);
    chk(rresp, `SC_RESP_SLVERR);
  endtask
  task automatic t_brownout();
    bod <= 1;
    wait_cyc(3);
    chk(bo_irq, 1'b1);
    chk(core_n, 1'b1);
    bod <= 0;
    wr(`SC_OFF_PBOR, 32'h2);
    bod <= 1;
    wait_cyc(40);
    chk(core_n, 1'b0);
    bod <= 0;
    wait_cyc(30);
    chk(core_n, 1'b1);
    rd(`SC_OFF_CAUSE, rd_v);
    chk(rd_v, 32'h6);
    wr(`SC_OFF_PBOR, 32'h0);
  endtask
  task automatic t_core_req();
    creq <= 1;
    wait_cyc(3);
    chk(core_n, 1'b0);
    creq <= 0;
    wait_cyc(30);
    chk(core_n, 1'b1);
    rd(`SC_OFF_CAUSE, rd_v);
    chk(rd_v, 32'h16);
  endtask
  // load 16: first zero about 16 cycles after run, second 17 later
  task automatic t_watchdog();
    wr(`SC_OFF_WDLOAD, 32'h10);
    wr(`SC_OFF_WDCTL, 32'h3);
    wait_cyc(20);
    chk(wd_irq, 1'b1);
    chk(core_n, 1'b1);
    wait_cyc(16);
    chk(core_n, 1'b0);
    wait_cyc(30);
    chk(core_n, 1'b1);
    chk(wd_irq, 1'b0);
    rd(`SC_OFF_CAUSE, rd_v);
    chk(rd_v, 32'h1e);
  endtask
  task automatic t_soft_reset();
    wr(`SC_OFF_SOFT1, 32'h0000_0020);
    wait_cyc(2);
    chk(prst_n[63:32], 32'hffff_ffdf);
    chk(prst_n[31:0], 32'hffff_ffff);
    chk(prst_n[95:64], 32'hffff_ffff);
    wr(`SC_OFF_SOFT1, 32'h0);
    wait_cyc(2);
    chk(prst_n[63:32], 32'hffff_ffff);
  endtask
  task automatic t_misc();
    wr(`SC_OFF_REGUL, 32'h5a);
    chk(trim, 8'h5a);
    wr(`SC_OFF_MAIN_OSC, 32'h1);
    chk(cken, 1'b1);
    nmi_p <= 1;
    wait_cyc(3);
    chk(nmi_o, 1'b0);
    nmi_en <= 1;
    wait_cyc(3);
    chk(nmi_o, 1'b1);
    nmi_p <= 0;
  endtask
  task automatic t_osc_fail();
    ofail <= 1;
    wait_cyc(2);
    ofail <= 0;
    chk(core_n, 1'b0);
    wait_cyc(30);
    chk(core_n, 1'b1);
    chk(nmi_o, 1'b1);
    rd(`SC_OFF_CAUSE, rd_v);
    chk(rd_v, 32'h0001_0000);
    wr(`SC_OFF_CAUSE, 32'h0001_0000);
    wait_cyc(2);
    chk(nmi_o, 1'b0);
  endtask
  task automatic t_clock_select();
    logic [31:0] n;
    for (int i = 0; i < 6; i++) begin
      // main oscillator ticks run from time zero, so it is already stable
      wr(`SC_OFF_RUN_CFG, cfg[i]);
      wait_cyc(30);
      chk(src_act, exp_src[i]);
      chk(pllen, exp_src[i] == 3'h5);
      // only main and pll tick with a period that never slips
      if (exp_src[i] == 3'h0 || exp_src[i] == 3'h5) begin
        n = 32'h0;
        repeat (10) begin
          @(posedge aclk);
          n = n + sclk_en;
        end
        chk(n, (exp_src[i] == 3'h5) ? 32'ha : 32'h5);
      end
    end
  endtask
  task automatic t_pin_reset();
    ext_n <= 0;
    wait_cyc(3);
    chk(core_n, 1'b0);
    ext_n <= 1;
    wait_cyc(30);
    chk(core_n, 1'b1);
    rd(`SC_OFF_CAUSE, rd_v);
    chk(rd_v, 32'h1);
  endtask
  initial begin
    wait_cyc(3);
    aresetn <= 1;
    wait_cyc(30);
    t_power_on();
    t_brownout();
    t_core_req();
    t_watchdog();
    t_soft_reset();
    t_misc();
    t_osc_fail();
    t_clock_select();
    t_pin_reset();
    results();
  end
endmodule
